// ===== design/qu_top.v
// How it works
// - Style select high: reset pin at 1 clears registers and outputs.
// - Style select low: reset pin acts at 0 with same effect.
// - During reset serial output idles and serial input is ignored.
// - Strobe falling edge writes data bus into addressed register.
// - Strobe rising edge drives addressed register onto data bus.
// - Receive-ready output summarises all four receive buffers.
// - Receive-ready low while any channel holds an unread character.
// - Receive-ready high once no channel holds an unread character.
// - Transmit-ready low while any channel has transmit space.
// - Transmit-ready high only when every transmit buffer is full.
// - Each channel's receive status is readable per channel.
// - Each channel has an active-low clear-to-send input.
// - Clear-to-send state reads in modem status bit 4.
// - Data-set-ready is status only, never gates data.
// - Carrier-detect input at 0 reports carrier present.
// - Modem control bit 0 set drives terminal-ready low.
// - Modem control bit 0 clear returns terminal-ready high.
// - Rates derive from the oscillator clock through each channel's divisor.
// - Address bits 4..3 pick channel A, B, C or D.
// - Serial output is 1 in reset; otherwise it follows the transmit line.
`include "qu_map.vh"

module qu_top (
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire        bus_style_i,
  input  wire        reset_pin_i,
  input  wire        cs_n_i,
  input  wire [4:0]  register_channel_addr_i,
  input  wire        rw_strobe_n_i,
  input  wire [7:0]  data_i,
  output wire [7:0]  data_o,
  output wire        data_oe_o,
  output wire        rx_data_avail_n_o,
  output wire        tx_space_avail_n_o,
  input  wire [3:0]  cts_n_i,
  input  wire [3:0]  dsr_n_i,
  input  wire [3:0]  carrier_detect_n_i,
  output wire [3:0]  dtr_n_o,
  input  wire [3:0]  rx_char_valid_i,
  input  wire [31:0] rx_char_data_i,
  output wire [3:0]  tx_char_valid_o,
  output wire [31:0] tx_char_data_o,
  input  wire [3:0]  tx_char_taken_i,
  input  wire [3:0]  tx_line_i,
  output wire [3:0]  tx_o,
  input  wire [3:0]  rx_i,
  output wire [3:0]  rx_line_o,
  output wire [3:0]  baud_tick_o,
  output wire        in_reset_o
);

  // Bus sequencer states, one-hot.
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_LOW   = 3'b010;
  localparam [2:0] ST_DRIVE = 3'b100;

  // One-hot channel pick from the address; used for writes and reads.
  function [3:0] chan_dec;
    input [4:0] addr;
    begin
      case (addr[`QU_ADDR_CH_MSB:`QU_ADDR_CH_LSB])
        2'b00:   chan_dec = 4'b0001;
        2'b01:   chan_dec = 4'b0010;
        2'b10:   chan_dec = 4'b0100;
        2'b11:   chan_dec = 4'b1000;
        default: chan_dec = 4'b0000;
      endcase
    end
  endfunction

  wire [13:0] sync_in;
  wire [13:0] sync_out;
  wire [3:0]  cts_s;
  wire [3:0]  dsr_s;
  wire [3:0]  cd_s;
  wire        strobe_s;
  wire        reset_pin_s;

  reg         strobe_d_reg;
  reg         soft_rst_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [7:0]  data_o_reg;
  reg         data_oe_reg;
  reg         rx_avail_n_reg;
  reg         tx_space_n_reg;
  reg  [3:0]  tx_o_reg;
  reg  [3:0]  rx_line_reg;

  wire        strobe_fall;
  wire        strobe_rise;
  wire        sel;
  wire [3:0]  chan_hit;
  wire [3:0]  wr_en;
  wire [3:0]  rd_en;
  wire [2:0]  reg_sel;
  wire [31:0] rdata_all;
  wire [3:0]  rx_full;
  wire [3:0]  tx_full;
  reg  [7:0]  rdata_mux;

  // The reset pin, the strobe and the modem inputs pass a synchroniser.
  assign sync_in = {reset_pin_i, rw_strobe_n_i, carrier_detect_n_i,
                    dsr_n_i, cts_n_i};

  qu_sync #(
    .W (14)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (sync_in),
    .sync_o    (sync_out)
  );

  assign cts_s       = sync_out[3:0];
  assign dsr_s       = sync_out[7:4];
  assign cd_s        = sync_out[11:8];
  assign strobe_s    = sync_out[12];
  assign reset_pin_s = sync_out[13];

  // The reset pin's sense follows the bus style; held as a level so
  // everything stays cleared for as long as the pin is asserted.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_rst_reg <= 1'b1;
    end else if (bus_style_i) begin
      soft_rst_reg <= reset_pin_s;
    end else begin
      soft_rst_reg <= ~reset_pin_s;
    end
  end

  // Edge detection works on the synchronised strobe only.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobe_d_reg <= 1'b1;
    end else begin
      strobe_d_reg <= strobe_s;
    end
  end

  assign strobe_fall = strobe_d_reg & ~strobe_s;
  assign strobe_rise = ~strobe_d_reg & strobe_s;

  // Select and address must already be stable at the edge; the
  // synchroniser delay means the host holds them two cycles longer.
  assign sel      = ~cs_n_i & ~soft_rst_reg;
  assign chan_hit = chan_dec(register_channel_addr_i);
  assign reg_sel  =
    register_channel_addr_i[`QU_ADDR_REG_MSB:`QU_ADDR_REG_LSB];
  assign wr_en    = {4{strobe_fall & sel}} & chan_hit;
  assign rd_en    = {4{strobe_rise & sel}} & chan_hit;

  // Bus sequencer: a falling edge writes, a rising edge reads, and
  // the read data stays on the bus until the next fall or deselect.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (strobe_fall && sel) begin
          state_next = ST_LOW;
        end else if (strobe_rise && sel) begin
          state_next = ST_DRIVE;
        end
      end
      ST_LOW: begin
        if (!sel) begin
          state_next = ST_IDLE;
        end else if (strobe_rise) begin
          state_next = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        if (!sel) begin
          state_next = ST_IDLE;
        end else if (strobe_fall) begin
          state_next = ST_LOW;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
    end else if (soft_rst_reg) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Read data mux across the four channels.
  always @* begin
    rdata_mux = 8'h00;
    case (chan_hit)
      4'b0001: rdata_mux = rdata_all[7:0];
      4'b0010: rdata_mux = rdata_all[15:8];
      4'b0100: rdata_mux = rdata_all[23:16];
      4'b1000: rdata_mux = rdata_all[31:24];
      default: rdata_mux = 8'h00;
    endcase
  end

  // Data bus driver, registered so the pins never glitch.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o_reg  <= 8'h00;
      data_oe_reg <= 1'b0;
    end else if (soft_rst_reg) begin
      data_o_reg  <= 8'h00;
      data_oe_reg <= 1'b0;
    end else begin
      if (strobe_rise && sel) begin
        data_o_reg <= rdata_mux;
      end
      data_oe_reg <= (state_next == ST_DRIVE);
    end
  end

  // The four channels.
  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_chan
      qu_chan u_chan (
        .sys_clk_i  (sys_clk_i),
        .rst_n_i    (rst_n_i),
        .clr_i      (soft_rst_reg),
        .wr_i       (wr_en[c]),
        .rd_i       (rd_en[c]),
        .reg_sel_i  (reg_sel),
        .wdata_i    (data_i),
        .rdata_o    (rdata_all[c*8+7:c*8]),
        .rx_valid_i (rx_char_valid_i[c]),
        .rx_data_i  (rx_char_data_i[c*8+7:c*8]),
        .tx_taken_i (tx_char_taken_i[c]),
        .cts_n_i    (cts_s[c]),
        .dsr_n_i    (dsr_s[c]),
        .cd_n_i     (cd_s[c]),
        .rx_full_o  (rx_full[c]),
        .tx_full_o  (tx_full[c]),
        .tx_data_o  (tx_char_data_o[c*8+7:c*8]),
        .dtr_n_o    (dtr_n_o[c]),
        .tick_o     (baud_tick_o[c])
      );
    end
  endgenerate

  // Summary pins: any unread character pulls receive-ready low; only
  // four full transmit buffers let transmit-ready go high.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_avail_n_reg <= 1'b1;
      tx_space_n_reg <= 1'b0;
    end else begin
      rx_avail_n_reg <= ~(|rx_full);
      tx_space_n_reg <= &tx_full;
    end
  end

  // Serial pins are forced idle while reset holds.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_o_reg    <= 4'hf;
      rx_line_reg <= 4'hf;
    end else if (soft_rst_reg) begin
      tx_o_reg    <= 4'hf;
      rx_line_reg <= 4'hf;
    end else begin
      tx_o_reg    <= tx_line_i;
      rx_line_reg <= rx_i;
    end
  end

  assign data_o             = data_o_reg;
  assign data_oe_o          = data_oe_reg;
  assign rx_data_avail_n_o  = rx_avail_n_reg;
  assign tx_space_avail_n_o = tx_space_n_reg;
  assign tx_char_valid_o    = tx_full;
  assign tx_o               = tx_o_reg;
  assign rx_line_o          = rx_line_reg;
  assign in_reset_o         = soft_rst_reg;

endmodule

// ===== include/qu_map.vh
`ifndef QU_MAP_VH
`define QU_MAP_VH

// Register offsets inside one channel, selected by address bits 2..0.
`define QU_OFS_HOLD     3'h0
`define QU_OFS_DIV      3'h3
`define QU_OFS_MCTL     3'h4
`define QU_OFS_LSTAT    3'h5
`define QU_OFS_MSTAT    3'h6

// Address fields of the five-bit register and channel address.
`define QU_ADDR_REG_LSB  0
`define QU_ADDR_REG_MSB  2
`define QU_ADDR_CH_LSB   3
`define QU_ADDR_CH_MSB   4

// Field positions in the modem control register.
`define QU_MCTL_DTR_BIT  0

// Field positions in the modem status register.
`define QU_MSTAT_DCTS_BIT 0
`define QU_MSTAT_DDSR_BIT 1
`define QU_MSTAT_DCD_BIT  3
`define QU_MSTAT_CTS_BIT  4
`define QU_MSTAT_DSR_BIT  5
`define QU_MSTAT_CD_BIT   7

// Field positions in the line status register.
`define QU_LSTAT_RDY_BIT  0
`define QU_LSTAT_THE_BIT  5
`define QU_LSTAT_TEM_BIT  6

// Reset values.
`define QU_MCTL_RST   8'h00
`define QU_DIV_RST    8'h00
`define QU_BYTE_RST   8'h00

`endif

// ===== design/qu_sync.v
// Two-flop synchroniser for a group of independent levels.
module qu_sync #(
  parameter W = 1
) (
  input  wire         sys_clk_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // The first stage feeds only the second; nothing else looks at it.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= {W{1'b1}};
      sync_reg <= {W{1'b1}};
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

// ===== design/qu_chan.v
`include "qu_map.vh"

// One channel: holding registers, modem control and status, rate tick.
module qu_chan (
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  input  wire       clr_i,
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire [2:0] reg_sel_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] rdata_o,
  input  wire       rx_valid_i,
  input  wire [7:0] rx_data_i,
  input  wire       tx_taken_i,
  input  wire       cts_n_i,
  input  wire       dsr_n_i,
  input  wire       cd_n_i,
  output wire       rx_full_o,
  output wire       tx_full_o,
  output wire [7:0] tx_data_o,
  output wire       dtr_n_o,
  output wire       tick_o
);

  reg [7:0] rx_hold_reg;
  reg       rx_full_reg;
  reg [7:0] tx_hold_reg;
  reg       tx_full_reg;
  reg [7:0] mctl_reg;
  reg       dtr_n_reg;
  reg [7:0] div_reg;
  reg [7:0] div_cnt_reg;
  reg       tick_reg;
  reg [2:0] prev_reg;
  reg [3:0] delta_reg;
  wire      rd_hold;
  wire      rd_mstat;
  wire [2:0] now_act;

  assign rd_hold  = rd_i && (reg_sel_i == `QU_OFS_HOLD);
  assign rd_mstat = rd_i && (reg_sel_i == `QU_OFS_MSTAT);
  assign now_act  = {~cd_n_i, ~dsr_n_i, ~cts_n_i};

  // Buffer flags: a new character beats a same-cycle read and a new write a
  // same-cycle take, so neither is lost; only clr_i wins over both.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_hold_reg <= `QU_BYTE_RST;
      rx_full_reg <= 1'b0;
      tx_hold_reg <= `QU_BYTE_RST;
      tx_full_reg <= 1'b0;
    end else if (clr_i) begin
      rx_hold_reg <= `QU_BYTE_RST;
      rx_full_reg <= 1'b0;
      tx_hold_reg <= `QU_BYTE_RST;
      tx_full_reg <= 1'b0;
    end else begin
      if (rx_valid_i) begin
        rx_hold_reg <= rx_data_i;
        rx_full_reg <= 1'b1;
      end else if (rd_hold) begin
        rx_full_reg <= 1'b0;
      end
      if (wr_i && reg_sel_i == `QU_OFS_HOLD) begin
        tx_hold_reg <= wdata_i;
        tx_full_reg <= 1'b1;
      end else if (tx_taken_i) begin
        tx_full_reg <= 1'b0;
      end
    end
  end

  // Modem control; the terminal-ready pin never touches the data path.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mctl_reg  <= `QU_MCTL_RST;
      dtr_n_reg <= 1'b1;
      div_reg   <= `QU_DIV_RST;
    end else if (clr_i) begin
      mctl_reg  <= `QU_MCTL_RST;
      dtr_n_reg <= 1'b1;
      div_reg   <= `QU_DIV_RST;
    end else if (wr_i && reg_sel_i == `QU_OFS_MCTL) begin
      mctl_reg  <= wdata_i;
      dtr_n_reg <= ~wdata_i[`QU_MCTL_DTR_BIT];
    end else if (wr_i && reg_sel_i == `QU_OFS_DIV) begin
      div_reg   <= wdata_i;
    end
  end

  // Rate tick from the oscillator clock; divisor zero stops it.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_reg <= 8'h00;
      tick_reg    <= 1'b0;
    end else if (clr_i || div_reg == 8'h00) begin
      div_cnt_reg <= 8'h00;
      tick_reg    <= 1'b0;
    end else if (div_cnt_reg == 8'h00) begin
      div_cnt_reg <= div_reg - 8'h01;
      tick_reg    <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg - 8'h01;
      tick_reg    <= 1'b0;
    end
  end

  // Change flags on the modem inputs; a change beats the read clear.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg  <= 3'h0;
      delta_reg <= 4'h0;
    end else if (clr_i) begin
      prev_reg  <= now_act;
      delta_reg <= 4'h0;
    end else begin
      prev_reg <= now_act;
      delta_reg[`QU_MSTAT_DCTS_BIT] <= (now_act[0] ^ prev_reg[0]) ||
        (delta_reg[`QU_MSTAT_DCTS_BIT] && !rd_mstat);
      delta_reg[`QU_MSTAT_DDSR_BIT] <= (now_act[1] ^ prev_reg[1]) ||
        (delta_reg[`QU_MSTAT_DDSR_BIT] && !rd_mstat);
      delta_reg[2] <= 1'b0;
      delta_reg[`QU_MSTAT_DCD_BIT] <= (now_act[2] ^ prev_reg[2]) ||
        (delta_reg[`QU_MSTAT_DCD_BIT] && !rd_mstat);
    end
  end

  // Read data for the addressed register.
  always @* begin
    rdata_o = 8'h00;
    case (reg_sel_i)
      `QU_OFS_HOLD:  rdata_o = rx_hold_reg;
      `QU_OFS_DIV:   rdata_o = div_reg;
      `QU_OFS_MCTL:  rdata_o = mctl_reg;
      `QU_OFS_LSTAT: begin
        rdata_o[`QU_LSTAT_RDY_BIT] = rx_full_reg;
        rdata_o[`QU_LSTAT_THE_BIT] = ~tx_full_reg;
        rdata_o[`QU_LSTAT_TEM_BIT] = ~tx_full_reg;
      end
      `QU_OFS_MSTAT: begin
        rdata_o[3:0] = delta_reg;
        rdata_o[`QU_MSTAT_CTS_BIT] = now_act[0];
        rdata_o[`QU_MSTAT_DSR_BIT] = now_act[1];
        rdata_o[`QU_MSTAT_CD_BIT]  = now_act[2];
      end
      default: rdata_o = 8'h00;
    endcase
  end

  assign rx_full_o = rx_full_reg;
  assign tx_full_o = tx_full_reg;
  assign tx_data_o = tx_hold_reg;
  assign dtr_n_o   = dtr_n_reg;
  assign tick_o    = tick_reg;

endmodule

// ===== verification/qu_top_asserts.sv
module qu_top_asserts (
  input wire       sys_clk_i,
  input wire       rst_n_i,
  input wire       bus_style_i,
  input wire       reset_pin_i,
  input wire       cs_n_i,
  input wire       rw_strobe_n_i,
  input wire [7:0] data_o,
  input wire       data_oe_o,
  input wire       rx_data_avail_n_o,
  input wire       tx_space_avail_n_o,
  input wire [3:0] dtr_n_o,
  input wire [3:0] rx_char_valid_i,
  input wire [3:0] tx_char_valid_o,
  input wire [3:0] tx_line_i,
  input wire [3:0] tx_o,
  input wire [3:0] rx_i,
  input wire [3:0] rx_line_o,
  input wire       in_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Reset pin held in its active sense for four edges forces reset.
  AST_PIN_HIGH: assert property (
    (bus_style_i && reset_pin_i) [*4] |-> in_reset_o)
    else $error("reset pin high did not reset");
  AST_PIN_LOW: assert property (
    (!bus_style_i && !reset_pin_i) [*4] |-> in_reset_o)
    else $error("reset pin low did not reset");
  // Outputs sit at their idle levels from the second cycle of reset onward.
  AST_RST_OUT: assert property (
    in_reset_o && $past(in_reset_o) |->
    dtr_n_o == 4'hf && tx_o == 4'hf && rx_line_o == 4'hf)
    else $error("outputs not idle in reset");
  // Outside reset the serial lines are plain registered copies.
  AST_LINE_COPY: assert property (
    !in_reset_o && !$past(in_reset_o) |->
    tx_o == $past(tx_line_i) && rx_line_o == $past(rx_i))
    else $error("serial line copy wrong");
  // Transmit summary is the AND of all full flags, one cycle late.
  AST_TX_SUM: assert property (
    !in_reset_o && !$past(in_reset_o) |->
    tx_space_avail_n_o == &$past(tx_char_valid_o))
    else $error("transmit summary wrong");
  AST_RX_SUM: assert property (
    (|rx_char_valid_i) && !in_reset_o ##1 !in_reset_o
    |=> !rx_data_avail_n_o)
    else $error("receive summary not low");
  // Terminal-ready only moves during a selected write strobe.
  AST_DTR_WR: assert property (
    $changed(dtr_n_o) && !in_reset_o |-> !rw_strobe_n_i && !cs_n_i)
    else $error("terminal ready moved without a write");
  AST_OE_RISE: assert property (
    $rose(data_oe_o) |-> !cs_n_i && $past(rw_strobe_n_i, 3))
    else $error("bus driven without a read strobe");
  AST_OE_DROP: assert property (
    cs_n_i [*2] |=> !data_oe_o)
    else $error("bus still driven after deselect");
endmodule

bind qu_top qu_top_asserts qu_top_asserts_inst (.sys_clk_i, .rst_n_i,
  .bus_style_i, .reset_pin_i, .cs_n_i, .rw_strobe_n_i, .data_o, .data_oe_o,
  .rx_data_avail_n_o, .tx_space_avail_n_o, .dtr_n_o, .rx_char_valid_i,
  .tx_char_valid_o, .tx_line_i, .tx_o, .rx_i, .rx_line_o, .in_reset_o);

// ===== verification/qu_host_model.sv
// Host side of the combined-strobe bus; tasks are called by the bench.
module qu_host_model (
  input  wire        sys_clk_i,
  output logic       cs_n_o,
  output logic [4:0] addr_o,
  output logic       strobe_n_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_o = 1'b1;
    addr_o = 5'h00;
    strobe_n_o = 1'b1;
    data_o = 8'h00;
  end
  // Falling strobe writes; the rise comes deselected so it reads nothing.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    addr_o <= a;
    data_o <= d;
    repeat (2) @(posedge sys_clk_i);
    strobe_n_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    cs_n_o <= 1'b1;
    data_o <= ~d;
    repeat (2) @(posedge sys_clk_i);
    strobe_n_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
  endtask
  // Deselected fall first, then a selected rise performs the read.
  task automatic rd(input logic [4:0] a);
    @(posedge sys_clk_i);
    strobe_n_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    addr_o <= a;
    repeat (2) @(posedge sys_clk_i);
    strobe_n_o <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    cs_n_o <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
  endtask
endmodule

// ===== verification/qu_top_tb_top.sv
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end

module qu_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, style = 1'b1, rpin = 1'b0;
  logic cs_n, strobe_n, oe, rxn, txn, oe_q, in_rst;
  logic [4:0] addr;
  logic [7:0] di, dout, b;
  logic [3:0] cts = 4'hf, dsr = 4'hf, cd = 4'hf, dtr, rxv = 4'h0;
  logic [3:0] tkn = 4'h0, txl = 4'hf, rxl = 4'hf, txo, rxo, txv, xa, xb, xc;
  logic [31:0] rxd = 32'h0, txd, r, bt;
  logic [15:0] q[$];
  logic [15:0] e;
  logic [3:0] tick;
  logic [7:0] nt, nz;
  int num_errors = 0, checks = 0;

  always #5 clk = ~clk;

  qu_top qu_top_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .bus_style_i(style),
    .reset_pin_i(rpin), .cs_n_i(cs_n), .register_channel_addr_i(addr),
    .rw_strobe_n_i(strobe_n), .data_i(di), .data_o(dout), .data_oe_o(oe),
    .rx_data_avail_n_o(rxn), .tx_space_avail_n_o(txn), .cts_n_i(cts),
    .dsr_n_i(dsr), .carrier_detect_n_i(cd), .dtr_n_o(dtr),
    .rx_char_valid_i(rxv), .rx_char_data_i(rxd), .tx_char_valid_o(txv),
    .tx_char_data_o(txd), .tx_char_taken_i(tkn), .tx_line_i(txl),
    .tx_o(txo), .rx_i(rxl), .rx_line_o(rxo), .baud_tick_o(tick),
    .in_reset_o(in_rst));
  qu_host_model qu_host_model_inst (.sys_clk_i(clk), .cs_n_o(cs_n),
    .addr_o(addr), .strobe_n_o(strobe_n), .data_o(di));

  task automatic summarize();
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Bounded wait for internal reset to end.
  task automatic wait_ready();
    int n;
    n = 0;
    while (in_rst !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    `CHK(in_rst, 1'b0)
    repeat (2) @(posedge clk);
  endtask

  // Queue a masked expectation, then read.
  task automatic rdx(input logic [4:0] a, input logic [7:0] m,
                     input logic [7:0] v);
    q.push_back({m, v});
    qu_host_model_inst.rd(a);
  endtask

  // Each new read answer is matched against the oldest note.
  always @(posedge clk) begin
    oe_q <= oe;
    if (oe === 1'b1 && oe_q !== 1'b1) begin
      if (q.size() == 0) `CHK(oe, 1'b0)
      else begin
        e = q.pop_front();
        `CHK(dout & e[15:8], e[7:0] & e[15:8])
      end
    end
  end

  // Serial lines wander randomly so the copy path is exercised.
  // Own draw here, so the main sequence keeps sole use of r.
  always @(posedge clk) begin
    {txl, rxl} <= 8'($urandom);
  end

  // Generous limit; the whole sequence needs about six hundred cycles.
  initial begin
    #400000;
    num_errors++;
    summarize();
  end

  initial begin
    r = $urandom(34596);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wait_ready();
    `CHK({dtr, txn, rxn}, 6'h3d)
    for (int c = 0; c < 4; c++) begin
      qu_host_model_inst.wr({c[1:0], 3'h4}, 8'h01);
      `CHK(dtr, ~(4'h1 << c))
      qu_host_model_inst.wr({c[1:0], 3'h4}, 8'h00);
      `CHK(dtr, 4'hf)
    end
    // Divisor 3 on channel A: one tick in every three clocks, none
    // on the other channels whose divisor is still zero.
    qu_host_model_inst.wr(5'h03, 8'h03);
    rdx(5'h03, 8'hff, 8'h03);
    nt = 8'h00;
    nz = 8'h00;
    repeat (30) begin
      @(posedge clk);
      nt = nt + tick[0];
      nz = nz + (|tick[3:1]);
    end
    `CHK({nt, nz}, 16'h0a00)
    // Modem status: settle, then random changes, then deltas cleared.
    for (int p = 0; p < 3; p++) begin
      r = $urandom;
      {xa, xb, xc} = (p == 1) ? r[11:0] : 12'h000;
      @(posedge clk);
      cts <= cts ^ xa;
      dsr <= dsr ^ xb;
      cd <= cd ^ xc;
      repeat (6) @(posedge clk);
      for (int c = 0; c < 4; c++)
        rdx({c[1:0], 3'h6}, p == 0 ? 8'hb0 : 8'hff, {~cd[c], 1'b0, ~dsr[c],
            ~cts[c], xc[c], 1'b0, xb[c], xa[c]});
    end
    // Two channels receive; the summary clears only after both are read.
    bt = $urandom;
    rxd <= bt;
    rxv <= 4'b1010;
    @(posedge clk);
    rxv <= 4'h0;
    repeat (3) @(posedge clk);
    `CHK(rxn, 1'b0)
    rdx(5'h0d, 8'hff, 8'h61);
    rdx(5'h08, 8'hff, bt[15:8]);
    `CHK(rxn, 1'b0)
    rdx(5'h18, 8'hff, bt[31:24]);
    `CHK(rxn, 1'b1)
    rdx(5'h1d, 8'hff, 8'h60);
    // Fill every transmit holding register in turn.
    bt = $urandom;
    for (int c = 0; c < 4; c++) begin
      b = bt[8*c +: 8];
      qu_host_model_inst.wr({c[1:0], 3'h0}, b);
      `CHK(txn, c == 3)
    end
    `CHK({txv, txd}, {4'hf, bt})
    @(posedge clk);
    tkn <= 4'h4;
    @(posedge clk);
    tkn <= 4'h0;
    repeat (3) @(posedge clk);
    `CHK({txv, txn}, 5'h16)
    // Reset pin in both senses.
    qu_host_model_inst.wr(5'h04, 8'h01);
    rpin <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK({in_rst, dtr, txo}, 9'h1ff)
    rpin <= 1'b0;
    wait_ready();
    style <= 1'b0;
    rpin <= 1'b1;
    repeat (4) @(posedge clk);
    qu_host_model_inst.wr(5'h14, 8'h01);
    `CHK(dtr, 4'hb)
    rpin <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK({in_rst, dtr, rxo}, 9'h1ff)
    rpin <= 1'b1;
    wait_ready();
    `CHK({txv, txn, q.size() == 0}, 6'h01)
    summarize();
  end
endmodule
